// >>> logic/pec_ctl_if.sv
// Control levels from the register bank, plus the speed status input, passed to the line logic
`timescale 1ns/100ps
interface pec_ctl_if;
  logic scr_dis;
  logic nrzi;
  logic speed_100;
  modport core (output scr_dis, output nrzi, output speed_100);
  modport link (input scr_dis, input nrzi, input speed_100);
endinterface

// >>> logic/pec_ext_ctl.sv
// Extended control register, strap capture and transmit symbol path
//
// Rules for this block and for management access
// R1: Management arms override first, then writes the register with protected bits.
// R2: While armed, the next management write may change protected bits.
// R3: Override enable resets to zero and clears after the next write.
// R4: Management must re-arm before changing protected bits in another register.
// R5: Reserved bits 14..11, 4 and 1 read as zero.
// R6: Management writes zero into reserved bits on every write.
// R7: Port address is sampled from LED pins at reset into bits 10..6.
// R8: Software reset leaves the latched port address unchanged.
// R9: Setting scrambler test mode forces the descrambler out of lock.
// R10: Encoding bit picks NRZ (0) or NRZI (1) at 100 Mb/s; resets to one.
// R11: With invalid-code bit zero, standard 4B/5B translation is used.
// R12: Invalid mode with error asserted maps nibbles 0..7 to zero plus nibble.
// R13: Nibbles 8..F map to 00000,01101,01100,10001,10000,11001,11000,11111.
// R14: Scrambler disable resets zero; one bypasses transmit and receive scrambling.
// R15: Scrambling only acts in 100 Mb/s operation.
// R16: The arming write itself does not consume the override permission.
`timescale 1ns/100ps
module pec_ext_ctl
  import pec_pkg::*;
(
  // Clocks and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        link_clk_i,
  // Management access
  input  wire logic        mgmt_wr_i,
  input  wire logic        mgmt_rd_i,
  input  wire logic [4:0]  mgmt_reg_addr_i,
  input  wire logic [15:0] mgmt_wdata_i,
  output logic [15:0]      mgmt_rdata_o,
  output logic             mgmt_rvalid_o,
  output logic             override_write_allow_o,
  input  wire logic        sw_reset_i,
  // Address strap pins
  input  wire logic        led_shared_addr_pin_4_i,
  input  wire logic        led_shared_addr_pin_3_i,
  input  wire logic        led_shared_addr_pin_2_i,
  input  wire logic        led_shared_addr_pin_1_i,
  input  wire logic        led_shared_addr_pin_0_i,
  output logic [4:0]       phy_addr_o,
  // Core status and receive controls
  input  wire logic        speed_100_i,
  output logic             descr_force_unlock_o,
  output logic             descr_bypass_o,
  // MAC transmit nibbles
  input  wire logic        mac_tx_valid_i,
  output logic             mac_tx_ready_o,
  input  wire logic        mac_tx_en_i,
  input  wire logic        mac_tx_er_i,
  input  wire logic [3:0]  mac_txd_i,
  // Line side
  output logic [4:0]       line_code_o,
  output logic             line_code_valid_o
);
  localparam pec_top_st_t ST_RST = '{
    arm:      ARM_RST,
    scr_test: SCR_TEST_RST,
    nrzi:     NRZI_RST,
    inv_en:   INV_RST,
    scr_dis:  SCR_DIS_RST,
    default:  '0
  };

  pec_top_st_t st_r;
  pec_top_st_t st_nxt;
  logic        wr_ext;
  logic        arm_write;
  logic [15:0] reg_val;
  logic [4:0]  tx_sym;
  logic        fifo_vld;
  logic        fifo_rdy;
  logic [4:0]  fifo_sym;

  pec_ctl_if ctl_if ();

  // 4B/5B translation, with the test mapping when the invalid-code bit is set and the error input is high
  function automatic logic [4:0] encode(input logic [3:0] nib,
                                        input logic       en,
                                        input logic       er,
                                        input logic       alt);
    logic [4:0] s;
    s = SYM_IDLE;
    if (!en) begin
      s = SYM_IDLE;
    end else if (er && alt) begin
      if (!nib[3]) begin
        s = {1'b0, nib}; // [R12]
      end else begin
        case (nib[2:0]) // [R13]
          3'h0:    s = 5'h00;
          3'h1:    s = 5'h0D;
          3'h2:    s = 5'h0C;
          3'h3:    s = 5'h11;
          3'h4:    s = 5'h10;
          3'h5:    s = 5'h19;
          3'h6:    s = 5'h18;
          default: s = 5'h1F;
        endcase
      end
    end else if (er) begin
      s = SYM_HALT;
    end else begin
      case (nib) // [R11]
        4'h0:    s = 5'h1E;
        4'h1:    s = 5'h09;
        4'h2:    s = 5'h14;
        4'h3:    s = 5'h15;
        4'h4:    s = 5'h0A;
        4'h5:    s = 5'h0B;
        4'h6:    s = 5'h0E;
        4'h7:    s = 5'h0F;
        4'h8:    s = 5'h12;
        4'h9:    s = 5'h13;
        4'hA:    s = 5'h16;
        4'hB:    s = 5'h17;
        4'hC:    s = 5'h1A;
        4'hD:    s = 5'h1B;
        4'hE:    s = 5'h1C;
        default: s = 5'h1D;
      endcase
    end
    return s;
  endfunction

  assign wr_ext    = mgmt_wr_i && (mgmt_reg_addr_i == EXT_CTL_ADDR);
  assign arm_write = wr_ext && mgmt_wdata_i[BIT_ARM];

  // Reserved positions are never stored, so they always read back zero
  always_comb begin
    reg_val = '0; // [R5]
    reg_val[BIT_ARM]           = st_r.arm;
    reg_val[ADDR_MSB:ADDR_LSB] = st_r.phy_addr;
    reg_val[BIT_SCR_TEST]      = st_r.scr_test;
    reg_val[BIT_NRZI]          = st_r.nrzi;
    reg_val[BIT_INV]           = st_r.inv_en;
    reg_val[BIT_SCR_DIS]       = st_r.scr_dis;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.pin_m = {led_shared_addr_pin_4_i, led_shared_addr_pin_3_i,
                    led_shared_addr_pin_2_i, led_shared_addr_pin_1_i,
                    led_shared_addr_pin_0_i};
    st_nxt.pin_s = st_r.pin_m;
    // Strap settles through both sync stages before it is latched
    if (st_r.strap_cnt != STRAP_DONE) begin
      st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
    end
    if (st_r.strap_cnt == STRAP_CAPTURE) begin
      st_nxt.phy_addr = st_r.pin_s; // [R7]
    end
    st_nxt.unlock = 1'b0;
    if (mgmt_wr_i) begin
      // Any write spends the permission; only the arming write re-arms
      st_nxt.arm = arm_write; // [R3] [R16]
    end
    if (wr_ext) begin
      st_nxt.scr_test = mgmt_wdata_i[BIT_SCR_TEST];
      st_nxt.nrzi     = mgmt_wdata_i[BIT_NRZI];
      st_nxt.inv_en   = mgmt_wdata_i[BIT_INV];
      st_nxt.scr_dis  = mgmt_wdata_i[BIT_SCR_DIS];
      st_nxt.unlock   = mgmt_wdata_i[BIT_SCR_TEST] && !st_r.scr_test; // [R9]
    end
    if (sw_reset_i) begin
      // Control bits return to defaults; the strapped address is kept
      st_nxt.arm      = ARM_RST; // [R8]
      st_nxt.scr_test = SCR_TEST_RST;
      st_nxt.nrzi     = NRZI_RST;
      st_nxt.inv_en   = INV_RST;
      st_nxt.scr_dis  = SCR_DIS_RST;
      st_nxt.unlock   = 1'b0;
    end
    st_nxt.bypass = st_nxt.scr_dis || !speed_100_i; // [R14] [R15]
    st_nxt.rvalid = mgmt_rd_i;
    if (mgmt_rd_i) begin
      st_nxt.rdata = (mgmt_reg_addr_i == EXT_CTL_ADDR) ? reg_val : '0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) st_r <= ST_RST;
    else          st_r <= st_nxt;
  end

  // Other registers see this as permission for protected bits on this write
  assign override_write_allow_o = mgmt_wr_i && st_r.arm; // [R2]
  assign mgmt_rdata_o         = st_r.rdata;
  assign mgmt_rvalid_o        = st_r.rvalid;
  assign phy_addr_o           = st_r.phy_addr;
  assign descr_force_unlock_o = st_r.unlock;
  assign descr_bypass_o       = st_r.bypass;

  assign ctl_if.scr_dis   = st_r.scr_dis;
  assign ctl_if.nrzi      = st_r.nrzi;
  assign ctl_if.speed_100 = speed_100_i;

  // Translation happens here so the line domain only sees whole symbols
  assign tx_sym = encode(mac_txd_i, mac_tx_en_i, mac_tx_er_i, st_r.inv_en);

  pec_fifo #(
    .WIDTH (SYM_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .wclk_i     (clk_i),
    .rst_n_i    (rst_n_i),
    .wr_valid_i (mac_tx_valid_i),
    .wr_ready_o (mac_tx_ready_o),
    .wr_data_i  (tx_sym),
    .rclk_i     (link_clk_i),
    .rd_valid_o (fifo_vld),
    .rd_ready_i (fifo_rdy),
    .rd_data_o  (fifo_sym)
  );

  pec_link u_link (
    .link_clk_i   (link_clk_i),
    .rst_n_i      (rst_n_i),
    .ctl          (ctl_if.link),
    .sym_valid_i  (fifo_vld),
    .sym_ready_o  (fifo_rdy),
    .sym_i        (fifo_sym),
    .code_o       (line_code_o),
    .code_valid_o (line_code_valid_o)
  );

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_arm_write;
    arm_write && !sw_reset_i;
  endsequence

  sequence s_spend_write;
    mgmt_wr_i && !arm_write;
  endsequence

  sequence s_strap_latch;
    st_r.strap_cnt == STRAP_CAPTURE ##1 st_r.strap_cnt == STRAP_DONE;
  endsequence

  AST_ARM_KEPT: assert property (s_arm_write |=> st_r.arm) // [R16]
    else $error("arming write did not arm override");

  AST_ARM_SPENT: assert property ( // [R3]
    st_r.arm ##0 s_spend_write |=> !st_r.arm)
    else $error("override stayed armed after a write");

  AST_ARM_HOLD: assert property ( // [R3]
    st_r.arm && !mgmt_wr_i && !sw_reset_i |=> st_r.arm)
    else $error("override cleared without a write");

  // Station spacing leaves three idle cycles before the protected write
  AST_PERMIT: assert property ( // [R2]
    s_arm_write ##1 (!mgmt_wr_i && !sw_reset_i)[*3] ##1 mgmt_wr_i
      |-> override_write_allow_o)
    else $error("armed write not granted permission");

  AST_NO_PERMIT: assert property ( // [R3]
    override_write_allow_o |-> $past(arm_write)
      || ($past(st_r.arm) && !$past(mgmt_wr_i)))
    else $error("permission granted without arming");

  AST_RSVD_ZERO: assert property ( // [R5]
    mgmt_rvalid_o |-> mgmt_rdata_o[14:11] == 4'h0
      && !mgmt_rdata_o[4] && !mgmt_rdata_o[1])
    else $error("reserved bit read as one");

  AST_STRAP: assert property ( // [R7]
    s_strap_latch |-> phy_addr_o == $past(st_r.pin_s))
    else $error("strapped address not latched");

  AST_ADDR_KEEP: assert property ( // [R8]
    st_r.strap_cnt == STRAP_DONE |=> $stable(phy_addr_o))
    else $error("port address changed after capture");

  AST_UNLOCK: assert property ( // [R9]
    wr_ext && mgmt_wdata_i[BIT_SCR_TEST] && !st_r.scr_test && !sw_reset_i
      |=> descr_force_unlock_o ##1 !descr_force_unlock_o)
    else $error("test mode did not force descrambler unlock");

  AST_SW_DEFAULT: assert property ( // [R10]
    sw_reset_i |=> st_r.nrzi && !st_r.scr_dis && !st_r.inv_en)
    else $error("control bits not at defaults after soft reset");

  AST_10M_BYPASS: assert property ( // [R15]
    !speed_100_i |=> descr_bypass_o)
    else $error("descrambler active at 10 Mb/s");

  AST_STD_MAP: assert property ( // [R11]
    !st_r.inv_en && mac_tx_en_i && !mac_tx_er_i && mac_txd_i == 4'h0
      |-> tx_sym == 5'h1E)
    else $error("standard mapping wrong for nibble 0");

  AST_ALT_LOW: assert property ( // [R12]
    st_r.inv_en && mac_tx_en_i && mac_tx_er_i && !mac_txd_i[3]
      |-> tx_sym == {1'b0, mac_txd_i})
    else $error("test mapping wrong for low nibble");

  AST_ALT_HIGH: assert property ( // [R13]
    st_r.inv_en && mac_tx_en_i && mac_tx_er_i && mac_txd_i == 4'h9
      |-> tx_sym == 5'h0D)
    else $error("test mapping wrong for nibble 9");

  AST_ALT_TOP: assert property ( // [R13]
    st_r.inv_en && mac_tx_en_i && mac_tx_er_i && mac_txd_i == 4'hF
      |-> tx_sym == 5'h1F)
    else $error("test mapping wrong for nibble 15");

  AST_HALT_MAP: assert property ( // [R11]
    !st_r.inv_en && mac_tx_en_i && mac_tx_er_i
      |-> tx_sym == SYM_HALT)
    else $error("error nibble not sent as halt");

  AST_RD_OTHER: assert property ( // [R5]
    mgmt_rd_i && mgmt_reg_addr_i != EXT_CTL_ADDR
      |=> mgmt_rdata_o == 16'h0000)
    else $error("foreign register read not zero");

  AST_RD_ARM: assert property ( // [R3]
    mgmt_rd_i && mgmt_reg_addr_i == EXT_CTL_ADDR
      |=> mgmt_rdata_o[BIT_ARM] == $past(st_r.arm))
    else $error("override bit misreported");

  AST_WR_CTRL: assert property ( // [R10] [R14]
    wr_ext && !sw_reset_i |=> st_r.nrzi == $past(mgmt_wdata_i[BIT_NRZI])
      && st_r.scr_dis == $past(mgmt_wdata_i[BIT_SCR_DIS]))
    else $error("coding controls not written");

  AST_BYP_ON: assert property ( // [R14]
    st_r.scr_dis && !wr_ext && !sw_reset_i |=> descr_bypass_o)
    else $error("descrambler active while disabled");

  AST_BYP_OFF: assert property ( // [R14]
    speed_100_i && !st_r.scr_dis && !wr_ext && !sw_reset_i
      |=> !descr_bypass_o)
    else $error("descrambler bypassed at 100 Mb/s");

  AST_RVALID: assert property (mgmt_rd_i |=> mgmt_rvalid_o) // [R5]
    else $error("read not answered next cycle");

  AST_NO_RVALID: assert property (!mgmt_rd_i |=> !mgmt_rvalid_o) // [R5]
    else $error("read answer without a request");
endmodule

// >>> logic/pec_fifo.sv
// Dual-clock symbol FIFO with gray pointers and registered read data
`timescale 1ns/100ps
module pec_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16
) (
  // Write side
  input  wire logic             wclk_i,
  input  wire logic             rst_n_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  input  wire logic [WIDTH-1:0] wr_data_i,
  // Read side
  input  wire logic             rclk_i,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i,
  output logic [WIDTH-1:0]      rd_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wbin;
    logic [AW:0]                 wgray;
    logic [AW:0]                 rg_m;
    logic [AW:0]                 rg_s;
  } pec_fw_t;

  typedef struct packed {
    logic [AW:0]      rbin;
    logic [AW:0]      rgray;
    logic [AW:0]      wg_m;
    logic [AW:0]      wg_s;
    logic [WIDTH-1:0] dout;
    logic             vld;
  } pec_fr_t;

  pec_fw_t w_r, w_nxt;
  pec_fr_t r_r, r_nxt;
  logic    full;
  logic    empty;
  logic    load;

  function automatic logic [AW:0] gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // Full when the write pointer has lapped the synced read pointer
  assign full  = w_r.wgray == {~w_r.rg_s[AW:AW-1], w_r.rg_s[AW-2:0]};
  assign empty = r_r.rgray == r_r.wg_s;
  assign load  = !empty && (!r_r.vld || rd_ready_i);
  assign wr_ready_o = !full;
  assign rd_valid_o = r_r.vld;
  assign rd_data_o  = r_r.dout;

  always_comb begin
    w_nxt = w_r;
    w_nxt.rg_m = r_r.rgray;
    w_nxt.rg_s = w_r.rg_m;
    if (wr_valid_i && !full) begin
      w_nxt.mem[w_r.wbin[AW-1:0]] = wr_data_i;
      w_nxt.wbin = w_r.wbin + 1'b1;
    end
    w_nxt.wgray = gray(w_nxt.wbin);
  end

  always_comb begin
    r_nxt = r_r;
    r_nxt.wg_m = w_r.wgray;
    r_nxt.wg_s = r_r.wg_m;
    if (rd_ready_i) begin
      r_nxt.vld = 1'b0;
    end
    if (load) begin
      r_nxt.dout = w_r.mem[r_r.rbin[AW-1:0]];
      r_nxt.vld  = 1'b1;
      r_nxt.rbin = r_r.rbin + 1'b1;
    end
    r_nxt.rgray = gray(r_nxt.rbin);
  end

  always_ff @(posedge wclk_i or negedge rst_n_i) begin
    if (!rst_n_i) w_r <= '0;
    else          w_r <= w_nxt;
  end

  always_ff @(posedge rclk_i or negedge rst_n_i) begin
    if (!rst_n_i) r_r <= '0;
    else          r_r <= r_nxt;
  end
endmodule

// >>> logic/pec_link.sv
// Line-clock stage: optional scrambling and NRZ or NRZI coding of symbols
`timescale 1ns/100ps
module pec_link
  import pec_pkg::*;
(
  // Clock and reset
  input  wire logic       link_clk_i,
  input  wire logic       rst_n_i,
  // Controls
  pec_ctl_if.link         ctl,
  // Symbol source
  input  wire logic       sym_valid_i,
  output logic            sym_ready_o,
  input  wire logic [4:0] sym_i,
  // Line
  output logic [4:0]      code_o,
  output logic            code_valid_o
);
  typedef struct packed {
    logic [2:0]  s1;
    logic [2:0]  s2;
    logic [10:0] lfsr;
    logic        level;
    logic [4:0]  code;
    logic        vld;
  } pec_lk_t;

  localparam pec_lk_t LK_RST = '{lfsr: LFSR_SEED, default: '0};

  pec_lk_t r, n;

  // One symbol per line clock, so the source is never held off here
  assign sym_ready_o  = 1'b1;
  assign code_o       = r.code;
  assign code_valid_o = r.vld;

  always_comb begin
    logic b;
    logic fb;
    logic scramble;
    b  = 1'b0;
    fb = 1'b0;
    scramble = 1'b0;
    n  = r;
    n.s1 = {ctl.scr_dis, ctl.nrzi, ctl.speed_100};
    n.s2 = r.s1;
    scramble = !r.s2[2] && r.s2[0]; // [R14] [R15]
    n.vld = sym_valid_i;
    if (sym_valid_i) begin
      for (int i = 4; i >= 0; i--) begin
        b = sym_i[i];
        if (scramble) begin
          fb = n.lfsr[10] ^ n.lfsr[8];
          n.lfsr = {n.lfsr[9:0], fb};
          b = b ^ fb;
        end
        if (r.s2[1]) begin // [R10]
          n.level = n.level ^ b;
          n.code[i] = n.level;
        end else begin
          n.code[i] = b;
        end
      end
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) r <= LK_RST;
    else          r <= n;
  end

  AST_LINK_PLAIN: assert property (@(posedge link_clk_i) // [R14]
    disable iff (!rst_n_i)
    (sym_valid_i && !r.s2[1] && !(!r.s2[2] && r.s2[0]))
      |=> code_o == $past(sym_i))
    else $error("unscrambled NRZ symbol altered");
endmodule

// >>> logic/pec_pkg.sv
// Constants and state types shared by the extended control block
package pec_pkg;
  localparam logic [4:0]  EXT_CTL_ADDR   = 5'h10;
  localparam int          BIT_ARM        = 15;
  localparam int          ADDR_LSB       = 6;
  localparam int          ADDR_MSB       = 10;
  localparam int          BIT_SCR_TEST   = 5;
  localparam int          BIT_NRZI       = 3;
  localparam int          BIT_INV        = 2;
  localparam int          BIT_SCR_DIS    = 0;
  localparam logic        ARM_RST        = 1'h0;
  localparam logic        SCR_TEST_RST   = 1'h0;
  localparam logic        NRZI_RST       = 1'h1;
  localparam logic        INV_RST        = 1'h0;
  localparam logic        SCR_DIS_RST    = 1'h0;
  localparam logic [1:0]  STRAP_CAPTURE  = 2'h2;
  localparam logic [1:0]  STRAP_DONE     = 2'h3;
  localparam logic [10:0] LFSR_SEED      = 11'h7FF;
  localparam int          SYM_W          = 5;
  localparam int          FIFO_DEPTH     = 16;
  localparam logic [4:0]  SYM_IDLE       = 5'h1F;
  localparam logic [4:0]  SYM_HALT       = 5'h04;

  typedef struct packed {
    logic [4:0]  pin_m;
    logic [4:0]  pin_s;
    logic [1:0]  strap_cnt;
    logic [4:0]  phy_addr;
    logic        arm;
    logic        scr_test;
    logic        nrzi;
    logic        inv_en;
    logic        scr_dis;
    logic        bypass;
    logic        unlock;
    logic [15:0] rdata;
    logic        rvalid;
  } pec_top_st_t;
endpackage

// >>> verification/pec_sta_model.sv
// Management station model driving the extended control register port
`timescale 1ns/100ps
module pec_sta_model (
  // Clock
  input  wire logic        clk_i,
  // Management access
  output logic             mgmt_wr_o,
  output logic             mgmt_rd_o,
  output logic [4:0]       mgmt_reg_addr_o,
  output logic [15:0]      mgmt_wdata_o,
  input  wire logic [15:0] mgmt_rdata_i,
  input  wire logic        mgmt_rvalid_i,
  input  wire logic        override_write_allow_i
);
  logic        allow_seen;
  logic        rd_ok;
  logic [15:0] rd_data;

  initial begin
    mgmt_wr_o       = 1'b0;
    mgmt_rd_o       = 1'b0;
    mgmt_reg_addr_o = 5'h00;
    mgmt_wdata_o    = 16'h0000;
    allow_seen      = 1'b0;
    rd_ok           = 1'b0;
    rd_data         = 16'h0000;
  end

  // Write exactly as given, reserved positions included
  task automatic wr_raw(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    mgmt_wr_o       <= 1'b1;
    mgmt_reg_addr_o <= a;
    mgmt_wdata_o    <= d;
    @(negedge clk_i);
    // Permission is combinational, so look at it before the taking edge
    allow_seen = override_write_allow_i;
    @(posedge clk_i);
    mgmt_wr_o    <= 1'b0;
    // Released data must not look like a held value
    mgmt_wdata_o <= ~d;
  endtask

  // Well-behaved write: in the extended control register, reserved and read-only positions go out as zero
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    wr_raw(a, (a == 5'h10) ? (d & 16'h802D) : d);
  endtask

  task automatic rd_reg(input logic [4:0] a);
    @(posedge clk_i);
    mgmt_rd_o       <= 1'b1;
    mgmt_reg_addr_o <= a;
    @(posedge clk_i);
    mgmt_rd_o <= 1'b0;
    rd_ok = 1'b0;
    for (int i = 0; i < 4 && !rd_ok; i++) begin
      @(negedge clk_i);
      if (mgmt_rvalid_i === 1'b1) begin
        rd_ok = 1'b1;
        rd_data = mgmt_rdata_i;
      end
    end
  endtask
endmodule

// >>> verification/tb.sv
// Self-checking bench for the extended control register and symbol path
`timescale 1ns/100ps
module tb;
  import pec_pkg::*;

  typedef struct packed {
    logic        raw;
    logic [15:0] wd;
    logic [15:0] rd;
    logic        byp;
  } pec_row_t;

  localparam pec_row_t ROWS [7] = '{
    '{1'b0, 16'h0000, 16'h0000, 1'b0}, '{1'b0, 16'h0008, 16'h0008, 1'b0},
    '{1'b0, 16'h0004, 16'h0004, 1'b0}, '{1'b0, 16'h0001, 16'h0001, 1'b1},
    '{1'b0, 16'h0020, 16'h0020, 1'b0}, '{1'b1, 16'h7FFF, 16'h002D, 1'b1},
    '{1'b1, 16'h7FD2, 16'h0000, 1'b0}};
  localparam logic [4:0] STD_SYM [16] = '{5'h1E, 5'h09, 5'h14, 5'h15,
    5'h0A, 5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B,
    5'h1C, 5'h1D};
  localparam logic [4:0] ALT_HI [8] = '{5'h00, 5'h0D, 5'h0C, 5'h11, 5'h10,
    5'h19, 5'h18, 5'h1F};

  logic        clk_i          = 1'b0;
  logic        link_clk_i     = 1'b0;
  logic        link_run       = 1'b1;
  logic        rst_n_i        = 1'b0;
  logic        sw_reset_i     = 1'b0;
  logic [4:0]  strap          = 5'h16;
  logic        speed_100_i    = 1'b1;
  logic        mac_tx_valid_i = 1'b0;
  logic        mac_tx_en_i    = 1'b1;
  logic        mac_tx_er_i    = 1'b0;
  logic [3:0]  mac_txd_i      = 4'h0;
  logic [15:0] ab             = 16'h0000;
  logic        mgmt_wr;
  logic        mgmt_rd;
  logic [4:0]  mgmt_addr;
  logic [15:0] mgmt_wdata;
  logic [15:0] mgmt_rdata_o;
  logic        mgmt_rvalid_o;
  logic        override_write_allow_o;
  logic [4:0]  phy_addr_o;
  logic        descr_force_unlock_o;
  logic        descr_bypass_o;
  logic        mac_tx_ready_o;
  logic [4:0]  line_code_o;
  logic        line_code_valid_o;
  logic [4:0]  got [$];
  int          num_errors     = 0;
  int          check_count    = 0;

  always #2 clk_i = ~clk_i;
  // Odd half period puts every other line edge on a core edge
  always #3 if (link_run) link_clk_i = ~link_clk_i;
  always @(negedge link_clk_i) begin
    if (line_code_valid_o === 1'b1) got.push_back(line_code_o);
  end

  pec_sta_model i_sta (
    .clk_i(clk_i), .mgmt_wr_o(mgmt_wr), .mgmt_rd_o(mgmt_rd),
    .mgmt_reg_addr_o(mgmt_addr), .mgmt_wdata_o(mgmt_wdata),
    .mgmt_rdata_i(mgmt_rdata_o), .mgmt_rvalid_i(mgmt_rvalid_o),
    .override_write_allow_i(override_write_allow_o));

  pec_ext_ctl i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i),
    .mgmt_wr_i(mgmt_wr), .mgmt_rd_i(mgmt_rd), .mgmt_reg_addr_i(mgmt_addr),
    .mgmt_wdata_i(mgmt_wdata), .mgmt_rdata_o(mgmt_rdata_o),
    .mgmt_rvalid_o(mgmt_rvalid_o),
    .override_write_allow_o(override_write_allow_o),
    .sw_reset_i(sw_reset_i), .led_shared_addr_pin_4_i(strap[4]),
    .led_shared_addr_pin_3_i(strap[3]), .led_shared_addr_pin_2_i(strap[2]),
    .led_shared_addr_pin_1_i(strap[1]), .led_shared_addr_pin_0_i(strap[0]),
    .phy_addr_o(phy_addr_o), .speed_100_i(speed_100_i),
    .descr_force_unlock_o(descr_force_unlock_o),
    .descr_bypass_o(descr_bypass_o), .mac_tx_valid_i(mac_tx_valid_i),
    .mac_tx_ready_o(mac_tx_ready_o), .mac_tx_en_i(mac_tx_en_i),
    .mac_tx_er_i(mac_tx_er_i), .mac_txd_i(mac_txd_i),
    .line_code_o(line_code_o), .line_code_valid_o(line_code_valid_o));

  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    i_sta.rd_reg(a);
    chk(i_sta.rd_ok === 1'b1 && i_sta.rd_data === e, "register read");
    if (i_sta.rd_ok !== 1'b1) tally_and_finish();
  endtask

  // Pins are set on the edge that asserts reset so they are stable through the capture
  task automatic hw_reset(input logic [4:0] pins);
    @(posedge clk_i);
    strap   <= pins;
    rst_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    ab = {5'h00, pins, 6'h00};
    repeat (6) @(posedge clk_i);
  endtask

  task automatic unlock_cnt(input logic [15:0] d, input int e);
    int p;
    p = 0;
    i_sta.wr_reg(EXT_CTL_ADDR, d);
    repeat (4) begin
      @(negedge clk_i);
      p += (descr_force_unlock_o === 1'b1);
    end
    chk(p == e, "descrambler unlock pulse count");
  endtask

  task automatic push(input logic [3:0] n, input logic er, output logic tk);
    @(posedge clk_i);
    mac_tx_valid_i <= 1'b1;
    mac_txd_i      <= n;
    mac_tx_er_i    <= er;
    tk = 1'b0;
    for (int i = 0; i < 8 && !tk; i++) begin
      @(negedge clk_i);
      tk = (mac_tx_ready_o === 1'b1);
      @(posedge clk_i);
    end
    mac_tx_valid_i <= 1'b0;
    mac_txd_i      <= ~n;
  endtask

  // Line clock held still so the buffer must fill, then refuse, then drain
  // Line level and scrambler are assumed at reset values for nz or sc
  task automatic batch(input logic er, input logic nz, input logic sc);
    logic        tk;
    int          acc;
    logic [4:0]  e;
    logic [10:0] lf;
    logic        lv;
    acc = 0;
    lf  = LFSR_SEED;
    lv  = 1'b0;
    got.delete();
    link_run = 1'b0;
    repeat (4) @(posedge clk_i);
    for (int n = 0; n < 17; n++) begin
      push(n[3:0], er, tk);
      acc += tk;
    end
    chk(acc == FIFO_DEPTH, "buffer accept count");
    link_run = 1'b1;
    for (int i = 0; i < 400 && got.size() < 16; i++) @(posedge clk_i);
    chk(got.size() == 16, "line symbol count");
    if (got.size() != 16) tally_and_finish();
    for (int n = 0; n < 16; n++) begin
      e = !er ? STD_SYM[n] : (n < 8) ? {1'b0, n[3:0]} : ALT_HI[n-8];
      for (int b = 4; b >= 0; b--) begin
        if (sc) begin
          lf   = {lf[9:0], lf[10] ^ lf[8]};
          e[b] = e[b] ^ lf[0];
        end
        lv = lv ^ (nz & e[b]);
        if (nz) e[b] = lv;
      end
      chk(got[n] === e, "line symbol value");
    end
  endtask

  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    hw_reset(5'h16);
    rd_chk(EXT_CTL_ADDR, 16'h0008 | ab);
    chk(phy_addr_o === 5'h16, "strap address");
    foreach (ROWS[i]) begin
      if (ROWS[i].raw) i_sta.wr_raw(EXT_CTL_ADDR, ROWS[i].wd);
      else i_sta.wr_reg(EXT_CTL_ADDR, ROWS[i].wd);
      rd_chk(EXT_CTL_ADDR, ROWS[i].rd | ab);
      chk(descr_bypass_o === ROWS[i].byp, "bypass level");
    end
    i_sta.wr_reg(EXT_CTL_ADDR, 16'h8001);
    chk(i_sta.allow_seen === 1'b0, "arming write allowed");
    rd_chk(EXT_CTL_ADDR, 16'h8001 | ab);
    i_sta.wr_reg(5'h05, 16'h0000);
    chk(i_sta.allow_seen === 1'b1, "armed write refused");
    i_sta.wr_reg(5'h05, 16'h0000);
    chk(i_sta.allow_seen === 1'b0, "second write allowed");
    rd_chk(EXT_CTL_ADDR, 16'h0001 | ab);
    rd_chk(5'h11, 16'h0000);
    i_sta.wr_reg(EXT_CTL_ADDR, 16'h802D);
    @(posedge clk_i);
    sw_reset_i <= 1'b1;
    @(posedge clk_i);
    sw_reset_i <= 1'b0;
    rd_chk(EXT_CTL_ADDR, 16'h0008 | ab);
    chk(phy_addr_o === 5'h16, "address after soft reset");
    unlock_cnt(16'h0000, 0);
    unlock_cnt(16'h0020, 1);
    unlock_cnt(16'h0020, 0);
    i_sta.wr_reg(EXT_CTL_ADDR, 16'h0000);
    @(posedge clk_i);
    speed_100_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(descr_bypass_o === 1'b1, "bypass at low speed");
    speed_100_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(descr_bypass_o === 1'b0, "bypass at high speed");
    i_sta.wr_reg(EXT_CTL_ADDR, 16'h0001);
    batch(1'b0, 1'b0, 1'b0);
    i_sta.wr_reg(EXT_CTL_ADDR, 16'h0005);
    batch(1'b1, 1'b0, 1'b0);
    i_sta.wr_reg(EXT_CTL_ADDR, 16'h0008);
    batch(1'b0, 1'b1, 1'b1);
    hw_reset(5'h09);
    rd_chk(EXT_CTL_ADDR, 16'h0008 | ab);
    chk(phy_addr_o === 5'h09, "strap address resampled");
    tally_and_finish();
  end
endmodule
